// ---- logic/srnvb_slave.sv ----
// Purpose: device end: two-wire slave, pointer, memory, supervisor, tamper
// Assumes: scl/sda and pins sampled by two flops
// Notes: time-copy freeze is an output flag
`timescale 1ns/1ns
`default_nettype none
module srnvb_slave
  import srnvb_pkg::*;
#(
  parameter int RECOVERY = srnvb_pkg::RECOVERY_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // link
  srnvb_link_if.device link,
  // supply and tamper pins
  input wire logic supply_bad,
  input wire logic on_battery,
  input wire logic tamper_one_input,
  input wire logic tamper_two_input,
  // system side
  output logic reset_out_b,
  output logic reset_out_oe,
  output logic sram_select_out,
  output logic sram_select_oe,
  output logic copy_frozen,
  output logic tamper_one_flag,
  output logic tamper_two_flag
);
  import srnvb_pkg::*;
  logic [1:0] scl_s, sda_s, pf_s, bat_s, t1_s, t2_s;
  logic scl_q, sda_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      pf_s <= 2'h3;
      bat_s <= 2'h0;
      t1_s <= 2'h0;
      t2_s <= 2'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], link.scl}; sda_s <= {sda_s[0], link.sda};
      pf_s <= {pf_s[0], supply_bad}; bat_s <= {bat_s[0], on_battery};
      t1_s <= {t1_s[0], tamper_one_input}; t2_s <= {t2_s[0], tamper_two_input};
      scl_q <= scl_s[1]; sda_q <= sda_s[1];
    end
  end
  wire scl_rise = scl_s[1] & ~scl_q;
  wire scl_fall = ~scl_s[1] & scl_q;
  wire start_c = scl_s[1] & scl_q & sda_q & ~sda_s[1];
  wire stop_c = scl_s[1] & scl_q & ~sda_q & sda_s[1];
  wire pf = pf_s[1];

  // ----------------------------------------
  // supervisor
  // ----------------------------------------
  logic [$clog2(RECOVERY+1)-1:0] rec_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) rec_q <= '0;
    else if (pf) rec_q <= '0;
    else if (rec_q != RECOVERY[$clog2(RECOVERY+1)-1:0]) rec_q <= rec_q + 1'b1;
  end
  wire protect = pf | (rec_q != RECOVERY[$clog2(RECOVERY+1)-1:0]);
  assign reset_out_b = 1'b0;
  assign reset_out_oe = protect & ~bat_s[1];
  assign sram_select_out = 1'b1;
  assign sram_select_oe = ~bat_s[1]; // high whenever not on battery, whether protect or not
  // note: non-protect select passes external enable outside this block

  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  srnvb_slv_e st_q;
  logic [7:0] sh_q, ptr_q;
  logic [3:0] bit_q;
  logic rd_q, first_q, drv_q, got_addr_q;
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] flags_q;
  wire [7:0] rd_byte = (ptr_q == FLAG_ADDR) ? flags_q : mem[ptr_q];
  wire in_range = ptr_q < 8'(MEM_DEPTH);
  // write ack clock: address byte only arms, pointer byte loads, data stores
  wire rx_ack_rise = (st_q == SRNVB_RACK) & scl_rise & ~rd_q & ~pf;
  wire load_ptr = rx_ack_rise & got_addr_q & first_q;
  wire store_byte = rx_ack_rise & got_addr_q & ~first_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= SRNVB_IDLE;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      bit_q <= 4'h0;
      rd_q <= 1'b0;
      first_q <= 1'b0;
      drv_q <= 1'b0;
      got_addr_q <= 1'b0;
    end else if (pf) begin
      st_q <= SRNVB_IDLE;
      ptr_q <= 8'h00;
      drv_q <= 1'b0;
      got_addr_q <= 1'b0;
    end else if (stop_c) begin
      st_q <= SRNVB_IDLE;
      drv_q <= 1'b0;
    end else if (start_c) begin
      st_q <= SRNVB_ADDR;
      bit_q <= 4'h0;
      drv_q <= 1'b0;
      got_addr_q <= 1'b0;
    end else begin
      unique case (st_q)
        SRNVB_IDLE: ;
        SRNVB_ADDR, SRNVB_RX: if (scl_rise) begin
          sh_q <= {sh_q[6:0], sda_s[1]};
          bit_q <= bit_q + 4'h1;
        end else if (scl_fall && bit_q == 4'h8) begin
          if (st_q == SRNVB_ADDR && sh_q[7:1] != SLAVE_ADDR) begin
            st_q <= SRNVB_IDLE;
          end else begin
            drv_q <= 1'b1;
            st_q <= SRNVB_RACK;
            if (st_q == SRNVB_ADDR) begin
              rd_q <= sh_q[0];
              first_q <= ~sh_q[0];
            end
          end
        end
        SRNVB_RACK: if (rx_ack_rise) begin
          got_addr_q <= 1'b1;
          if (load_ptr) begin
            ptr_q <= sh_q;
            first_q <= 1'b0;
          end else if (store_byte) begin
            ptr_q <= ptr_q + 8'h01;
          end
        end else if (scl_fall) begin
          bit_q <= 4'h0;
          st_q <= rd_q ? SRNVB_TX : SRNVB_RX;
          if (rd_q) begin
            sh_q <= rd_byte;
            drv_q <= ~rd_byte[7];
            rd_q <= 1'b0;
          end else begin
            drv_q <= 1'b0;
          end
        end
        SRNVB_TX: if (scl_fall) begin
          if (bit_q == 4'h7) begin
            drv_q <= 1'b0;
            st_q <= SRNVB_TACK;
          end else begin
            drv_q <= ~sh_q[6];
            sh_q <= {sh_q[6:0], 1'b0};
            bit_q <= bit_q + 4'h1;
          end
        end
        SRNVB_TACK: if (scl_rise) begin
          ptr_q <= ptr_q + 8'h01;
          st_q <= sda_s[1] ? SRNVB_IDLE : SRNVB_TACK;
          bit_q <= sda_s[1] ? 4'h0 : 4'hF;
        end else if (scl_fall && bit_q == 4'hF) begin
          sh_q <= rd_byte;
          drv_q <= ~rd_byte[7];
          bit_q <= 4'h0;
          st_q <= SRNVB_TX;
        end
        default: st_q <= SRNVB_IDLE;
      endcase
    end
  end
  // flag address and out-of-range bytes are dropped, not wrapped
  always_ff @(posedge core_clk) begin
    if (store_byte && in_range && ptr_q != FLAG_ADDR) begin
      mem[ptr_q] <= sh_q;
    end
  end
  assign copy_frozen = (st_q != SRNVB_IDLE) & (ptr_q <= CLOCK_LAST);
  assign link.sda_s_o = 1'b0;
  assign link.sda_s_oe = drv_q & ~bat_s[1];

  // ----------------------------------------
  // tamper
  // ----------------------------------------
  wire [7:0] treg1 = mem[TAMP1_ADDR];
  wire [7:0] treg2 = mem[TAMP2_ADDR];
  // normally open: trip at active level; normally closed: trip leaving it
  wire ev1 = treg1[TAMP_KIND_BIT] ? (t1_s[1] == treg1[TAMP_LEVEL_BIT]) : (t1_s[1] != treg1[TAMP_LEVEL_BIT]);
  wire ev2 = treg2[TAMP_KIND_BIT] ? (t2_s[1] == treg2[TAMP_LEVEL_BIT]) : (t2_s[1] != treg2[TAMP_LEVEL_BIT]);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) flags_q <= 8'h00;
    else begin
      flags_q[FLAG_T1_BIT] <= treg1[TAMP_ARM_BIT] & (flags_q[FLAG_T1_BIT] | ev1);
      flags_q[FLAG_T2_BIT] <= treg2[TAMP_ARM_BIT] & (flags_q[FLAG_T2_BIT] | ev2);
    end
  end
  assign tamper_one_flag = flags_q[FLAG_T1_BIT];
  assign tamper_two_flag = flags_q[FLAG_T2_BIT];
endmodule
`default_nettype wire

// ---- pkg/srnvb_pkg.sv ----
// Purpose: shared constants for the two-wire clock/nvram slave and its master
// Assumes: 125 MHz core_clk; link sampled through two-flop synchronisers
// Notes: Function list below
//
// Function
// - each byte followed by one acknowledge clock
// - slave acknowledges its own address byte and every byte it receives after it
// - acknowledger holds sda low during ack high
// - master withholds ack on last read byte
// - slave releases sda after withheld ack
// - addressed read: write pointer, restart, read
// - pointer advances only on acknowledge clock
// - read streams consecutive bytes until stop
// - freeze time copy while a transfer is active with pointer on clock
// - bare read starts at held pointer
// - first written byte loads pointer, rest store
// - write acknowledges address, pointer, each data
// - power fail deselects and write-protects
// - reset output held while supply bad
// - sram select forced inactive while supply bad
// - recovery interval keeps protection after return
// - below switchover reset, sram select and sda outputs released; tamper and freeze flags stay driven
// - two tamper inputs set flags when armed
// - switch kind and level select event
// - respond only to own slave address
// - power fail aborts transfer, clears pointer
package srnvb_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h68;
  localparam logic [7:0] CLOCK_LAST = 8'h07;
  localparam logic [7:0] FLAG_ADDR = 8'h0F;
  localparam logic [7:0] TAMP1_ADDR = 8'h14;
  localparam logic [7:0] TAMP2_ADDR = 8'h15;
  localparam int TAMP_ARM_BIT = 7;
  localparam int TAMP_KIND_BIT = 6;
  localparam int TAMP_LEVEL_BIT = 5;
  localparam int FLAG_T1_BIT = 0;
  localparam int FLAG_T2_BIT = 1;
  localparam int MEM_DEPTH = 160;
  localparam int RECOVERY_CYCLES = 1000;
  localparam int HALF_BIT_CYCLES = 40;
  // master register map (byte offsets)
  localparam logic [7:0] M_CTRL = 8'h00;
  localparam logic [7:0] M_STAT = 8'h04;
  localparam logic [7:0] M_TXD = 8'h08;
  localparam logic [7:0] M_RXD = 8'h0C;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [2:0] {
    SRNVB_IDLE = 3'h0, SRNVB_ADDR = 3'h1, SRNVB_RACK = 3'h2, SRNVB_RX = 3'h3,
    SRNVB_TX = 3'h4, SRNVB_TACK = 3'h5
  } srnvb_slv_e;
endpackage

// ---- pkg/srnvb_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface srnvb_link_if;
  logic scl_o, scl_oe, sda_m_o, sda_m_oe, sda_s_o, sda_s_oe;
  wire logic scl = scl_oe ? scl_o : 1'b1;
  wire logic sda = (sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o) ? 1'b0 : 1'b1;
  modport device (input scl, sda, output sda_s_o, sda_s_oe);
  modport host (input scl, sda, output scl_o, scl_oe, sda_m_o, sda_m_oe);
endinterface
`default_nettype wire

// ---- logic/srnvb_master.sv ----
// Purpose: host end: AHB-Lite controlled two-wire master
// Assumes: single slave, zero-wait slave response
// Notes: one byte per command
`timescale 1ns/1ns
`default_nettype none
module srnvb_master
  import srnvb_pkg::*;
#(
  parameter int HALF = srnvb_pkg::HALF_BIT_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // link
  srnvb_link_if.host link
);
  import srnvb_pkg::*;
  // ctrl: [0]=start [1]=stop [2]=write byte [3]=read byte [4]=ack to send(0=ack)
  logic [7:0] haddr_q, txd_q, rxd_q;
  logic wr_q, busy_q, rack_q;
  logic [4:0] cmd_q;
  logic [1:0] sda_sync;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) sda_sync <= 2'h3;
    else sda_sync <= {sda_sync[0], link.sda};
  end
  wire ap = hsel & (htrans == HTRANS_NONSEQ);
  wire go = wr_q & (haddr_q == M_CTRL) & ~busy_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin haddr_q <= 8'h00; wr_q <= 1'b0; txd_q <= 8'h00; end
    else begin
      wr_q <= ap & hwrite; haddr_q <= haddr;
      if (wr_q && haddr_q == M_TXD) txd_q <= hwdata[7:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire [31:0] rd_mux = (haddr_q == M_STAT) ? {30'h0, rack_q, busy_q} :
                       (haddr_q == M_RXD) ? {24'h0, rxd_q} : {27'h0, cmd_q};
  assign hrdata = rd_mux;

  // ----------------------------------------
  // bit sequencer: phases of 4 per bit, 9 bits per byte
  // ----------------------------------------
  logic [15:0] div_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [1:0] stage_q; // 0 start, 1 byte, 2 stop
  logic scl_q, sda_q;
  wire tick = busy_q & (div_q == 16'(HALF / 2));
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 16'h0; ph_q <= 2'h0; bit_q <= 4'h0; stage_q <= 2'h0; busy_q <= 1'b0;
      scl_q <= 1'b1; sda_q <= 1'b1; cmd_q <= 5'h0; rxd_q <= 8'h00; rack_q <= 1'b1;
    end else if (go) begin
      cmd_q <= hwdata[4:0]; busy_q <= 1'b1; div_q <= 16'h0; ph_q <= 2'h0; bit_q <= 4'h0;
      stage_q <= hwdata[0] ? 2'h0 : ((hwdata[3] | hwdata[2]) ? 2'h1 : 2'h2);
    end else if (busy_q) begin
      div_q <= tick ? 16'h0 : div_q + 16'h1;
      if (tick) begin
        ph_q <= ph_q + 2'h1;
        unique case (stage_q)
          2'h0: unique case (ph_q) // start: sda high, scl high, sda low, scl low
            2'h0: begin sda_q <= 1'b1; scl_q <= 1'b0; end
            2'h1: scl_q <= 1'b1;
            2'h2: sda_q <= 1'b0;
            2'h3: begin scl_q <= 1'b0;
              stage_q <= (cmd_q[3] | cmd_q[2]) ? 2'h1 : (cmd_q[1] ? 2'h2 : 2'h3); end
          endcase
          2'h1: unique case (ph_q) // nine clocks per byte
            2'h0: sda_q <= (bit_q == 4'h8) ? (cmd_q[3] ? cmd_q[4] : 1'b1)
                           : (cmd_q[2] ? txd_q[3'(7 - bit_q)] : 1'b1); // via sw sequence
            2'h1: scl_q <= 1'b1;
            2'h2: if (bit_q == 4'h8) rack_q <= sda_sync[1];
                  else rxd_q <= {rxd_q[6:0], sda_sync[1]};
            2'h3: begin scl_q <= 1'b0; bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h8) stage_q <= cmd_q[1] ? 2'h2 : 2'h3; end
          endcase
          2'h2: unique case (ph_q) // stop
            2'h0: sda_q <= 1'b0;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_q <= 1'b1;
            2'h3: stage_q <= 2'h3;
          endcase
          default: busy_q <= 1'b0;
        endcase
      end
    end
  end
  assign link.scl_o = scl_q;
  assign link.scl_oe = 1'b1;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = ~sda_q;
endmodule
`default_nettype wire

// ---- tb/srnvb_checker.sv ----
// Purpose: link and supervisor assertions for the slave/master pair
// Assumes: one core_clk domain, rst_b async low
// Notes: supply pins counted settled after four cycles
`timescale 1ns/1ns
`default_nettype none
module srnvb_checker #(
  parameter int RECOVERY = 20
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // link
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  // supervisor
  input wire logic supply_bad,
  input wire logic on_battery,
  input wire logic reset_out_b,
  input wire logic reset_out_oe,
  input wire logic sram_select_out,
  input wire logic sram_select_oe,
  input wire logic copy_frozen
);
  // margin for the two-flop pin synchroniser
  localparam int REC_HI = RECOVERY + 12;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_slave_still;
    !supply_bad && !on_battery && scl && $past(scl) |-> $stable(sda_s_oe & ~sda_s_o);
  endproperty
  a_slave_still: assert property (p_slave_still) else $error("slave moved sda while scl high");
  property p_rst_out;
    (supply_bad && !on_battery) [*4] |-> reset_out_oe && !reset_out_b;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset output not held on bad supply");
  property p_sram_off;
    (supply_bad && !on_battery) [*4] |-> sram_select_oe && sram_select_out;
  endproperty
  a_sram_off: assert property (p_sram_off) else $error("sram select not forced inactive");
  property p_no_bus;
    supply_bad [*4] |-> !sda_s_oe;
  endproperty
  a_no_bus: assert property (p_no_bus) else $error("slave drives sda on bad supply");
  property p_rec_hold;
    $fell(supply_bad) && !on_battery |-> (reset_out_oe && sram_select_oe) [*8];
  endproperty
  a_rec_hold: assert property (p_rec_hold) else $error("protection dropped early");
  property p_rec_end;
    $fell(supply_bad) && !on_battery |-> ##[RECOVERY:REC_HI] !reset_out_oe;
  endproperty
  a_rec_end: assert property (p_rec_end) else $error("recovery interval length wrong");
  property p_battery;
    on_battery [*4] |-> !sda_s_oe && !reset_out_oe && !sram_select_oe;
  endproperty
  a_battery: assert property (p_battery) else $error("output driven on battery");
  property p_thaw;
    scl && $past(scl) && $rose(sda) |-> ##[1:6] !copy_frozen;
  endproperty
  a_thaw: assert property (p_thaw) else $error("time copy still frozen after stop");
  property p_scl_high;
    $rose(scl) |-> scl [*4];
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("scl high phase too short");
  c_ack: cover property (scl && sda_s_oe && !sda_s_o);
  c_frozen: cover property ($rose(copy_frozen));
  c_fail: cover property ($fell(supply_bad));
endmodule
`default_nettype wire

// ---- tb/srnvb_tb.sv ----
// Purpose: random and corner traffic through master into slave
// Assumes: shortened bit and recovery counts
// Notes: expectations built from bytes the bench wrote
`timescale 1ns/1ns
`default_nettype none
module srnvb_tb;
  import srnvb_pkg::*;
  localparam int RECOV = 20;
  localparam logic [7:0] WADR = {SLAVE_ADDR, 1'b0};
  localparam logic [7:0] RADR = {SLAVE_ADDR, 1'b1};
  localparam logic [4:0] C_ST = 5'h05, C_TX = 5'h04, C_SP = 5'h02, C_RA = 5'h08, C_RN = 5'h1A;
  logic core_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic supply_bad = 1'b0, on_battery = 1'b0, t1_in = 1'b1, t2_in = 1'b1;
  logic reset_out_b, reset_out_oe, sram_select_out, sram_select_oe, copy_frozen, flag1, flag2;
  logic [7:0] haddr = 8'h00, p, b;
  logic [1:0] htrans = HTRANS_IDLE;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, st;
  logic [7:0] wb [3];
  integer seed = 32'h8d27;
  int error_cnt = 0, n_compared = 0;
  srnvb_link_if link ();
  srnvb_slave #(.RECOVERY(RECOV)) u_srnvb_slave (.core_clk(core_clk), .rst_b(rst_b), .link(link),
    .supply_bad(supply_bad), .on_battery(on_battery), .tamper_one_input(t1_in), .tamper_two_input(t2_in),
    .reset_out_b(reset_out_b), .reset_out_oe(reset_out_oe), .sram_select_out(sram_select_out),
    .sram_select_oe(sram_select_oe), .copy_frozen(copy_frozen), .tamper_one_flag(flag1),
    .tamper_two_flag(flag2));
  srnvb_master #(.HALF(8)) u_srnvb_master (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link(link));
  srnvb_checker #(.RECOVERY(RECOV)) u_srnvb_checker (.core_clk(core_clk), .rst_b(rst_b), .scl(link.scl),
    .sda(link.sda), .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe), .supply_bad(supply_bad),
    .on_battery(on_battery), .reset_out_b(reset_out_b), .reset_out_oe(reset_out_oe),
    .sram_select_out(sram_select_out), .sram_select_oe(sram_select_oe), .copy_frozen(copy_frozen));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // bench tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50) begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  // one byte command; wait bounded on busy
  task automatic cmd(input logic [4:0] c, input logic [7:0] tx, output logic [31:0] s);
    logic [31:0] d;
    int i;
    ahb(1'b1, M_TXD, {24'h0, tx}, d);
    ahb(1'b1, M_CTRL, {27'h0, c}, d);
    i = 0;
    do begin
      ahb(1'b0, M_STAT, 32'h0, s);
      i++;
    end while (s[0] !== 1'b0 && i < 3000);
    if (i >= 3000) begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic rx(input logic [4:0] c, output logic [7:0] v);
    logic [31:0] d;
    cmd(c, 8'h00, d);
    ahb(1'b0, M_RXD, 32'h0, d);
    v = d[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] s;
    cmd(C_ST, WADR, s);
    cmd(C_TX, a, s);
    cmd(C_TX, v, s);
    cmd(C_SP, 8'h00, s);
  endtask
  task automatic rd_at(input logic [7:0] a, output logic [7:0] v);
    logic [31:0] s;
    cmd(C_ST, WADR, s);
    cmd(C_TX, a, s);
    cmd(C_ST, RADR, s);
    rx(C_RN, v);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (RECOV + 20) @(posedge core_clk);
    p = 8'h20 + 8'($random(seed) & 32'h3F);
    for (int k = 0; k < 3; k++) wb[k] = 8'($random(seed));
    cmd(C_ST, WADR, st);
    chk(8'(st[1]), 8'h00);
    cmd(C_TX, p, st);
    chk(8'(st[1]), 8'h00);
    for (int k = 0; k < 3; k++) begin
      cmd(C_TX, wb[k], st);
      chk(8'(st[1]), 8'h00);
    end
    cmd(C_SP, 8'h00, st);
    cmd(C_ST, WADR, st);
    cmd(C_TX, p, st);
    cmd(C_ST, RADR, st);
    for (int k = 0; k < 3; k++) begin
      rx((k == 2) ? C_RN : C_RA, b);
      chk(b, wb[k]);
    end
    cmd(C_ST, WADR, st);
    cmd(C_TX, p + 8'h01, st);
    cmd(C_SP, 8'h00, st);
    cmd(C_ST, RADR, st);
    rx(C_RN, b);
    chk(b, wb[1]);
    cmd(C_ST, 8'hA0, st);
    chk(8'(st[1]), 8'h01);
    cmd(C_SP, 8'h00, st);
    cmd(C_ST, WADR, st);
    cmd(C_TX, CLOCK_LAST, st);
    chk(8'(copy_frozen), 8'h01);
    cmd(C_ST, RADR, st);
    rx(C_RA, b);
    chk(8'(copy_frozen), 8'h00);
    rx(C_RN, b);
    // every switch kind and trigger level on channel one; channel two kept unarmed
    wr(TAMP2_ADDR, 8'h00);
    for (int m = 0; m < 4; m++) begin
      t1_in <= m[0] ^ m[1];
      t2_in <= m[0] ^ m[1];
      wr(TAMP1_ADDR, 8'h00);
      wr(TAMP1_ADDR, {1'b1, m[1], m[0], 5'h00});
      chk(8'(flag1), 8'h00);
      t1_in <= ~(m[0] ^ m[1]);
      t2_in <= ~(m[0] ^ m[1]);
      repeat (6) @(posedge core_clk);
      chk(8'(flag1), 8'h01);
      chk(8'(flag2), 8'h00);
    end
    rd_at(FLAG_ADDR, b);
    chk(8'(b[FLAG_T1_BIT]), 8'h01);
    cmd(C_ST, WADR, st);
    cmd(C_TX, p, st);
    supply_bad <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk(8'(reset_out_oe & ~reset_out_b), 8'h01);
    chk(8'(sram_select_oe & sram_select_out), 8'h01);
    cmd(C_TX, ~wb[0], st);
    chk(8'(st[1]), 8'h01);
    cmd(C_SP, 8'h00, st);
    supply_bad <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk(8'(reset_out_oe), 8'h01);
    repeat (RECOV + 12) @(posedge core_clk);
    chk(8'(reset_out_oe), 8'h00);
    rd_at(p, b);
    chk(b, wb[0]);
    supply_bad <= 1'b1;
    on_battery <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk({5'h00, reset_out_oe, sram_select_oe, link.sda_s_oe}, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
